// [verilog/vrbs_pkg.sv]
/*
  Constants shared by the video RAM bus share block.
  Assumes a single 200 MHz clock and synchronous active-high reset.
*/
package vrbs_pkg;
  localparam int unsigned LINES_PER_ROW = 10;
  localparam int unsigned ROWS_PER_FRAME = 24;
  localparam int unsigned CHARS_PER_ROW = 80;
  localparam int unsigned ADDRS_PER_FRAME = 1920;
  localparam int unsigned DOT_COLS = 5;
  localparam int unsigned DOT_ROWS = 7;
  localparam int unsigned CODE_SET = 64;
  localparam int unsigned FRAME_RATE_HZ = 60;
  localparam int unsigned BLOCK_BYTES = 500;
  // Blanked scan line counter values (7, 8, 9)
  localparam logic [3:0] BLANK_LINE_A = 4'h7;
  localparam logic [3:0] BLANK_LINE_B = 4'h8;
  localparam logic [3:0] BLANK_LINE_C = 4'h9;
  localparam logic [3:0] CURSOR_LINE = 4'h9;
  // Page select codes from latched address bits 13:12
  localparam logic [1:0] PAGE_PERIPH = 2'h0;
  localparam logic [1:0] PAGE_TOP = 2'h1;
  localparam logic [1:0] PAGE_ROW = 2'h2;
  localparam logic [1:0] PAGE_CURSOR = 2'h3;
  localparam int unsigned PAGE_LSB = 12;
  localparam int unsigned PAGE_MSB = 13;
  localparam int unsigned PERIPH_BLOCKS = 8;
  localparam int unsigned BLOCK_IDX_W = 3;
endpackage

// [verilog/vrbs_dec_if.sv]
/*
  Interface carrying page decode results from the decoder to the top.
  Assumes both ends in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface vrbs_dec_if;
  logic [7:0] periph_sel;
  logic load_top;
  logic load_row;
  logic load_cursor;
  modport dec (output periph_sel, output load_top, output load_row,
    output load_cursor);
  modport use_side (input periph_sel, input load_top, input load_row,
    input load_cursor);
endinterface
`default_nettype wire

// [verilog/vrbs_page_dec.sv]
/*
  Page and block decoder for host_cpu memory cycles.
  Assumes page bits were latched from the multiplexed data bus.
*/
`timescale 1ns/1ps
`default_nettype none
module vrbs_page_dec
  import vrbs_pkg::*;
(
  input wire logic [1:0] page_i,
  input wire logic [11:0] addr_i,
  input wire logic cycle_i,
  vrbs_dec_if.dec dec
);
  import vrbs_pkg::*;

  // ********************************
  // Block index within a page
  // ********************************
  function automatic logic [BLOCK_IDX_W-1:0] block_of(input logic [11:0] a);
    logic [11:0] q;
    q = 12'(a / 12'(BLOCK_BYTES));
    block_of = q[BLOCK_IDX_W-1:0];
  endfunction

  logic [BLOCK_IDX_W-1:0] blk;
  logic in_range;
  assign blk = block_of(addr_i);
  // Past the last block the index would wrap onto block zero
  assign in_range = addr_i < 12'(PERIPH_BLOCKS * BLOCK_BYTES);

  genvar g;
  generate
    for (g = 0; g < PERIPH_BLOCKS; g++)
    begin : g_sel
      // Peripherals live in the first page
      assign dec.periph_sel[g] = cycle_i && (page_i == PAGE_PERIPH) &&
        (blk == BLOCK_IDX_W'(g)) && in_range;
    end
  endgenerate

  assign dec.load_top = cycle_i && (page_i == PAGE_TOP);
  assign dec.load_row = cycle_i && (page_i == PAGE_ROW);
  assign dec.load_cursor = cycle_i && (page_i == PAGE_CURSOR);
endmodule
`default_nettype wire

// [verilog/vrbs_top.sv]
/*
  Video RAM bus share glue: grants the bus to host_cpu on blanked scan
  lines and vertical blanking, disables the refresh controller address
  drivers, decodes pages, routes the receive interrupt.
  Assumes all inputs synchronous to CLOCK_I; the refresh controller
  steps its scan_line_count at horizontal blanking.
*/
// Summary of operation
// - Three of ten scan lines blanked except cursor
// - Grant host on blanked lines and vertical blanking
// - Bus available is decoded lines OR vertical blank, held until an open host cycle ends
// - Address enable low while host holds bus
// - Memory decoded in 500 byte blocks
// - Latch address bits 12,13 for four pages
// - Page zero peripherals, others load controller registers
// - Refresh 60 Hz, 1920 addresses, 24x80
// - Characters from 5x7 dots, 64 codes
// - Receive buffer full drives host sense input
// - Address enable low tristates, high drives
// - Line count changes at line boundaries only
`timescale 1ns/1ps
`default_nettype none
module vrbs_top
  import vrbs_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic [3:0] SCAN_LINE_COUNT_I,
  input wire logic LINE_RATE_CLK_I,
  input wire logic VBLANK_I,
  input wire logic CURSOR_EN_I,
  input wire logic HOST_ADDR_STROBE_I,
  input wire logic [7:0] HOST_DATA_I,
  input wire logic [11:0] HOST_ADDR_I,
  input wire logic HOST_CYCLE_I,
  input wire logic RX_FULL_I,
  output logic BUS_AVAIL_O,
  output logic ADDR_EN_O,
  output logic VIDEO_EN_O,
  output logic HOST_SENSE_O,
  output logic [7:0] PERIPH_SEL_O,
  output logic LOAD_TOP_O,
  output logic LOAD_ROW_O,
  output logic LOAD_CURSOR_O
);
  import vrbs_pkg::*;

  // ********************************
  // Layout checks
  // ********************************
  // Frame address count, and cell sizes that the blanked-line decode relies on
  if (ROWS_PER_FRAME * CHARS_PER_ROW != ADDRS_PER_FRAME)
  begin : g_bad_frame
    $error("frame address count does not match rows");
  end
  if (BLANK_LINE_A != 4'(DOT_ROWS) ||
    BLANK_LINE_C != 4'(LINES_PER_ROW - 1))
  begin : g_bad_cell
    $error("blanked lines do not follow the dot rows");
  end

  // ********************************
  // Grant decode
  // ********************************
  function automatic logic is_blank_line(input logic [3:0] lc);
    is_blank_line = (lc == BLANK_LINE_A) || (lc == BLANK_LINE_B) ||
      (lc == BLANK_LINE_C);
  endfunction

  typedef enum logic [1:0]
  {
    ST_DISP = 2'b01,
    ST_HOST = 2'b10
  } vrbs_state_t;

  vrbs_state_t state_q, state_d;
  logic lrc_q, lrc_d;
  logic [3:0] line_q, line_d;
  logic avail_q, avail_d;
  logic en_q, en_d;
  logic video_q, video_d;
  logic sense_q, sense_d;
  logic [1:0] page_q, page_d;
  logic [7:0] psel_q, psel_d;
  logic ltop_q, ltop_d, lrow_q, lrow_d, lcur_q, lcur_d;
  logic grant_req;
  logic host_busy;

  vrbs_dec_if dec_bus();

  vrbs_page_dec u_dec
  (
    .page_i(page_q),
    .addr_i(HOST_ADDR_I),
    .cycle_i(HOST_CYCLE_I),
    .dec(dec_bus.dec)
  );

  always_comb
  begin
    lrc_d = LINE_RATE_CLK_I;
    line_d = line_q;
    // Sample line count on line clock rising edge only
    if (LINE_RATE_CLK_I && !lrc_q)
    begin
      line_d = SCAN_LINE_COUNT_I;
    end
    grant_req = is_blank_line(line_q) || VBLANK_I;
    host_busy = HOST_CYCLE_I && (state_q == ST_HOST);
    state_d = state_q;
    case (state_q)
      ST_DISP:
      begin
        if (grant_req)
        begin
          state_d = ST_HOST;
        end
      end
      ST_HOST:
      begin
        // Hold grant until an open host cycle completes
        if (!grant_req && !host_busy)
        begin
          state_d = ST_DISP;
        end
      end
      default:
      begin
        state_d = ST_DISP;
      end
    endcase
    avail_d = (state_d == ST_HOST);
    en_d = (state_d != ST_HOST);
    // Blanked lines show video only for the cursor
    video_d = !VBLANK_I && (!is_blank_line(line_q) ||
      (CURSOR_EN_I && line_q == CURSOR_LINE));
    sense_d = RX_FULL_I;
    page_d = page_q;
    if (HOST_ADDR_STROBE_I)
    begin
      page_d = HOST_DATA_I[PAGE_MSB-8:PAGE_LSB-8];
    end
    psel_d = dec_bus.periph_sel;
    ltop_d = dec_bus.load_top && avail_q;
    lrow_d = dec_bus.load_row && avail_q;
    lcur_d = dec_bus.load_cursor && avail_q;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      state_q <= ST_DISP;
      lrc_q <= 1'b0;
      line_q <= 4'h0;
      avail_q <= 1'b0;
      en_q <= 1'b1;
      video_q <= 1'b0;
      sense_q <= 1'b0;
      page_q <= 2'h0;
      psel_q <= 8'h00;
      ltop_q <= 1'b0;
      lrow_q <= 1'b0;
      lcur_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      lrc_q <= lrc_d;
      line_q <= line_d;
      avail_q <= avail_d;
      en_q <= en_d;
      video_q <= video_d;
      sense_q <= sense_d;
      page_q <= page_d;
      psel_q <= psel_d;
      ltop_q <= ltop_d;
      lrow_q <= lrow_d;
      lcur_q <= lcur_d;
    end
  end

  assign BUS_AVAIL_O = avail_q;
  assign ADDR_EN_O = en_q;
  assign VIDEO_EN_O = video_q;
  assign HOST_SENSE_O = sense_q;
  assign PERIPH_SEL_O = psel_q;
  assign LOAD_TOP_O = ltop_q;
  assign LOAD_ROW_O = lrow_q;
  assign LOAD_CURSOR_O = lcur_q;

  // ********************************
  // Checks
  // ********************************
  a_enable_vs_grant: assert property (@(posedge CLOCK_I)
    disable iff (SYS_RST_I) BUS_AVAIL_O |-> !ADDR_EN_O)
    else $error("address enable high while host holds bus");
  a_vblank_grants: assert property (@(posedge CLOCK_I)
    disable iff (SYS_RST_I) VBLANK_I |=> BUS_AVAIL_O)
    else $error("no grant during vertical blanking");
  a_blank_line_grant: assert property (@(posedge CLOCK_I)
    disable iff (SYS_RST_I) is_blank_line(line_q) |=> BUS_AVAIL_O)
    else $error("no grant on blanked scan line");
  a_release_grant: assert property (@(posedge CLOCK_I)
    disable iff (SYS_RST_I) (!VBLANK_I && !is_blank_line(line_q) &&
    !HOST_CYCLE_I) |=> !BUS_AVAIL_O)
    else $error("grant held on active line");
  a_cycle_holds: assert property (@(posedge CLOCK_I)
    disable iff (SYS_RST_I) (BUS_AVAIL_O && HOST_CYCLE_I) |=> BUS_AVAIL_O)
    else $error("grant withdrawn during host cycle");
  a_line_step: assert property (@(posedge CLOCK_I)
    disable iff (SYS_RST_I) !(LINE_RATE_CLK_I && !lrc_q) |=> $stable(line_q))
    else $error("line count changed off line clock edge");
  a_video_blank: assert property (@(posedge CLOCK_I)
    disable iff (SYS_RST_I) (is_blank_line(line_q) && !CURSOR_EN_I) |=>
    !VIDEO_EN_O)
    else $error("video on blanked line without cursor");
  a_sense_route: assert property (@(posedge CLOCK_I)
    disable iff (SYS_RST_I) RX_FULL_I |=> HOST_SENSE_O)
    else $error("receive full not routed to sense");
  a_page_latch: assert property (@(posedge CLOCK_I)
    disable iff (SYS_RST_I) HOST_ADDR_STROBE_I |=>
    page_q == $past(HOST_DATA_I[5:4]))
    else $error("page bits not latched");
endmodule
`default_nettype wire

// [tb/vrbs_display_refresh_controller_model.sv]
/* Refresh controller stand-in: steps the scan line count with a
   line rate clock pulse and drives vertical blanking.
   Assumes the bench calls step from its main sequence. */
`timescale 1ns/1ps
`default_nettype none
module vrbs_refresh_model
(
  input wire logic clk_i,
  output logic [3:0] line_o,
  output logic lclk_o,
  output logic vblank_o
);
  initial
  begin
    line_o = 4'h0;
    lclk_o = 1'b0;
    vblank_o = 1'b0;
  end
  // Count and blanking change with the line clock rise only
  task automatic step(input logic [3:0] n, input logic v);
    @(posedge clk_i);
    line_o <= n;
    lclk_o <= 1'b1;
    vblank_o <= v;
    @(posedge clk_i);
    lclk_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// [tb/video_ram_bus_share_tb_top.sv]
/* Self-checking bench for the video RAM bus share block.
   Assumes the refresh controller model supplies line timing. */
`timescale 1ns/1ps
`default_nettype none
module video_ram_bus_share_tb_top;
  import vrbs_pkg::*;
  logic clk, rst, cur, stb, cyc, rx, lclk, vb, av, aen, ven, sns;
  logic lt, lr, lcu, v;
  logic [3:0] lc;
  logic [7:0] dat, psel;
  logic [11:0] adr, a_w;
  int n_mismatch, compares, i, g;
  int unsigned edge_a[3] = '{499, 500, 3999};

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  vrbs_refresh_model i_vrbs_refresh_model(.clk_i(clk), .line_o(lc),
    .lclk_o(lclk), .vblank_o(vb));
  vrbs_top i_vrbs_top(.CLOCK_I(clk), .SYS_RST_I(rst),
    .SCAN_LINE_COUNT_I(lc), .LINE_RATE_CLK_I(lclk), .VBLANK_I(vb),
    .CURSOR_EN_I(cur), .HOST_ADDR_STROBE_I(stb), .HOST_DATA_I(dat),
    .HOST_ADDR_I(adr), .HOST_CYCLE_I(cyc), .RX_FULL_I(rx),
    .BUS_AVAIL_O(av), .ADDR_EN_O(aen), .VIDEO_EN_O(ven),
    .HOST_SENSE_O(sns), .PERIPH_SEL_O(psel), .LOAD_TOP_O(lt),
    .LOAD_ROW_O(lr), .LOAD_CURSOR_O(lcu));

  function automatic logic blank(input logic [3:0] k);
    return k == BLANK_LINE_A || k == BLANK_LINE_B || k == BLANK_LINE_C;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic t_line(input logic [3:0] k, input logic b,
    input logic c);
    @(posedge clk);
    cur <= c;
    i_vrbs_refresh_model.step(k, b);
    #1;
    chk(8'(av), 8'(b | blank(k)));
    chk(8'(aen), 8'(!(b | blank(k))));
    if (!b)
      chk(8'(ven), 8'(!blank(k) | (c & k == CURSOR_LINE)));
  endtask

  task automatic t_dec(input logic [1:0] p, input logic [11:0] a);
    logic gr;
    logic [7:0] exp_sel, exp_ld;
    gr = av;
    @(posedge clk);
    stb <= 1'b1;
    dat <= (8'($urandom) & 8'hCF) | {2'b00, p, 4'h0};
    @(posedge clk);
    stb <= 1'b0;
    cyc <= 1'b1;
    adr <= a;
    @(posedge clk);
    cyc <= 1'b0;
    #1;
    exp_sel = p == PAGE_PERIPH ? 8'h01 << (a / BLOCK_BYTES) : 8'h00;
    chk(psel, exp_sel);
    exp_ld = (p == PAGE_PERIPH || !gr) ? 8'h00 : 8'(4'h8 >> p);
    chk(8'({lt, lr, lcu}), exp_ld);
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    {cur, stb, cyc, rx} = 4'h0;
    dat = 8'h00;
    adr = 12'h000;
    n_mismatch = 0;
    compares = 0;
    void'($urandom(32'h2273_4720));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(8'({av, aen}), 8'h01);
    $display("test reset done");
    for (i = 0; i < 16; i++)
      t_line(4'(i), 1'b0, 1'b0);
    t_line(CURSOR_LINE, 1'b0, 1'b1);
    t_line(4'h3, 1'b1, 1'b0);
    repeat (40)
      t_line(4'($urandom), 1'($urandom), 1'($urandom));
    $display("test grant done");
    for (g = 0; g < 2; g++)
    begin
      // Off the grant first, then on a blanked line
      t_line(g ? BLANK_LINE_B : 4'h2, 1'b0, 1'b0);
      for (i = 0; i < 12; i++)
      begin
        a_w = i < 3 ? 12'(edge_a[i]) : 12'($urandom % 4096);
        t_dec(2'(i / 3), a_w);
      end
    end
    t_dec(PAGE_PERIPH, 12'hFA0);
    t_dec(PAGE_PERIPH, 12'($urandom % 4096));
    t_dec(PAGE_CURSOR, 12'h000);
    t_dec(PAGE_TOP, 12'($urandom));
    $display("test decode done");
    // Open host cycle keeps the grant past the blanked line
    @(posedge clk);
    cyc <= 1'b1;
    i_vrbs_refresh_model.step(4'h2, 1'b0);
    #1;
    chk(8'({av, aen}), 8'h02);
    @(posedge clk);
    cyc <= 1'b0;
    @(posedge clk);
    #1;
    chk(8'({av, aen}), 8'h01);
    $display("test hold done");
    repeat (20)
    begin
      @(posedge clk);
      v = 1'($urandom);
      rx <= v;
      @(posedge clk);
      #1;
      chk(8'(sns), 8'(v));
    end
    $display("test sense done");
    results();
  end

  // Cuts a hang short
  initial
  begin
    #100000;
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
